// ### logic/aum_uncor_regs.sv
`timescale 1ns/100ps
`default_nettype none

`include "aum_params.svh"

module aum_uncor_regs
	import aum_pkg::*;
#(
	parameter logic [31:0] IMPL_BITS = `AUM_IMPL_DEFAULT,
	parameter bit          NO_OWN_NP = 1'b0
) (
	input  wire logic         clk,
	input  wire logic         sys_rst,
	input  wire logic         hot_rst,
	input  wire logic         cfg_wr,
	input  wire logic         cfg_rd,
	input  wire logic [11:0]  cfg_addr,
	input  wire logic [3:0]   cfg_be,
	input  wire logic [31:0]  cfg_wdata,
	output var  logic [31:0]  cfg_rdata,
	output var  logic         cfg_rd_ack,
	input  wire logic [31:0]  err_detect,
	input  wire logic [127:0] err_hdr,
	output var  logic         err_fatal_msg,
	output var  logic         err_nonfatal_msg,
	output var  logic [4:0]   first_err_ptr
);

	// Positions that really hold state; bit 0 and reserved bits never do
	localparam logic [31:0] IMPL_EFF = IMPL_BITS & `AUM_FIELD_BITS
		& ~`AUM_BIT_LEGACY
		& ~(NO_OWN_NP ? `AUM_BIT_CPL_TMO : 32'h00000000);

	localparam logic [31:0] MASK_DFLT = `AUM_MASK_DEFAULT;
	localparam logic [31:0] SEV_DFLT  = `AUM_SEV_DEFAULT;
	localparam logic [31:0] CPL_TMO_BIT = `AUM_BIT_CPL_TMO;

	function automatic aum_sel_e decode(input logic [11:0] addr);
		aum_sel_e sel;
		sel = AUM_SEL_NONE;
		if (addr[1:0] == 2'h0) begin
			if (addr == `AUM_OFF_STATUS) begin
				sel = AUM_SEL_STATUS;
			end else if (addr == `AUM_OFF_MASK) begin
				sel = AUM_SEL_MASK;
			end else if (addr == `AUM_OFF_SEVERITY) begin
				sel = AUM_SEL_SEV;
			end else if (addr == `AUM_OFF_CAPCTL) begin
				sel = AUM_SEL_CAPCTL;
			end else if (addr >= `AUM_OFF_HLOG_FIRST && addr <= `AUM_OFF_HLOG_LAST) begin
				sel = AUM_SEL_HLOG;
			end
		end
		return sel;
	endfunction

	// Lowest set bit wins when several errors arrive together
	function automatic logic [4:0] first_bit(input aum_word_t v);
		logic [4:0] pos;
		pos = 5'h00;
		for (int i = 31; i >= 0; i--) begin
			if (v[i]) begin
				pos = 5'(i);
			end
		end
		return pos;
	endfunction

	aum_sel_e  wr_sel;
	aum_sel_e  rd_sel;
	aum_word_t be_bits;
	aum_word_t mask;
	aum_word_t sev;
	aum_word_t status;
	aum_word_t next_status;
	aum_word_t unmasked;
	aum_word_t clr_bits;
	aum_word_t hlog [`AUM_HLOG_WORDS];
	aum_word_t next_hlog [`AUM_HLOG_WORDS];
	logic [`AUM_HLOG_IDX_W-1:0] hlog_idx;
	logic       log_valid;
	logic       next_log_valid;
	logic [4:0] next_ptr;
	logic       ptr_cleared;
	logic       next_fatal;
	logic       next_nonfatal;
	aum_word_t  next_rdata;
	logic       next_rd_ack;

	assign wr_sel   = decode(cfg_addr);
	assign rd_sel   = decode(cfg_addr);
	assign hlog_idx = 2'((cfg_addr - `AUM_OFF_HLOG_FIRST) >> 2);
	assign be_bits  = {{8{cfg_be[3]}}, {8{cfg_be[2]}}, {8{cfg_be[1]}}, {8{cfg_be[0]}}};

	// Mask and severity bits, one sticky cell each
	genvar g;
	generate
		for (g = 0; g < 32; g++) begin : g_ctl
			aum_ctl_bit #(
				.IMPL (IMPL_EFF[g]),
				.DFLT (MASK_DFLT[g])
			) u_mask (
				.clk     (clk),
				.sys_rst (sys_rst),
				.wr_en   (cfg_wr && wr_sel == AUM_SEL_MASK && be_bits[g]),
				.wr_data (cfg_wdata[g]),
				.q       (mask[g])
			);
			aum_ctl_bit #(
				.IMPL (IMPL_EFF[g]),
				.DFLT (SEV_DFLT[g] & ~(NO_OWN_NP & CPL_TMO_BIT[g]))
			) u_sev (
				.clk     (clk),
				.sys_rst (sys_rst),
				.wr_en   (cfg_wr && wr_sel == AUM_SEL_SEV && be_bits[g]),
				.wr_data (cfg_wdata[g]),
				.q       (sev[g])
			);
		end
	endgenerate

	// Error gating, status, pointer and header log
	assign unmasked = err_detect & IMPL_EFF & ~mask;
	assign clr_bits = (cfg_wr && wr_sel == AUM_SEL_STATUS) ? (cfg_wdata & be_bits) : 32'h00000000;
	// Clearing the status bit under the pointer frees the log for the next error
	assign ptr_cleared = log_valid && clr_bits[first_err_ptr];

	always_comb begin
		// Detection beats a same-cycle clear
		next_status = ((status & ~clr_bits) | err_detect) & IMPL_EFF;
		next_log_valid = log_valid && !ptr_cleared;
		next_ptr = first_err_ptr;
		for (int i = 0; i < `AUM_HLOG_WORDS; i++) begin
			next_hlog[i] = hlog[i];
		end
		if (unmasked != 32'h00000000 && (!log_valid || ptr_cleared)) begin
			next_log_valid = 1'b1;
			next_ptr = first_bit(unmasked);
			for (int i = 0; i < `AUM_HLOG_WORDS; i++) begin
				next_hlog[i] = err_hdr[32*i +: 32];
			end
		end
	end

	// Status, pointer and log are sticky as well
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			status        <= `AUM_STATUS_DEFAULT;
			log_valid     <= 1'b0;
			first_err_ptr <= 5'h00;
			for (int i = 0; i < `AUM_HLOG_WORDS; i++) begin
				hlog[i] <= 32'h00000000;
			end
		end else begin
			status        <= next_status;
			log_valid     <= next_log_valid;
			first_err_ptr <= next_ptr;
			for (int i = 0; i < `AUM_HLOG_WORDS; i++) begin
				hlog[i] <= next_hlog[i];
			end
		end
	end

	// Error messages toward the root complex
	always_comb begin
		next_fatal    = !hot_rst && ((unmasked & sev) != 32'h00000000);
		next_nonfatal = !hot_rst && ((unmasked & ~sev) != 32'h00000000);
	end

	// A hot reset only drops a message in flight, never sticky state
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			err_fatal_msg    <= 1'b0;
			err_nonfatal_msg <= 1'b0;
		end else begin
			err_fatal_msg    <= next_fatal;
			err_nonfatal_msg <= next_nonfatal;
		end
	end

	// Configuration read path; unmapped offsets read zero
	always_comb begin
		next_rd_ack = cfg_rd;
		next_rdata  = 32'h00000000;
		if (cfg_rd) begin
			case (rd_sel)
				AUM_SEL_STATUS: begin
					next_rdata = status;
				end
				AUM_SEL_MASK: begin
					next_rdata = mask;
				end
				AUM_SEL_SEV: begin
					next_rdata = sev;
				end
				AUM_SEL_CAPCTL: begin
					next_rdata = {27'h0000000, first_err_ptr};
				end
				AUM_SEL_HLOG: begin
					next_rdata = hlog[hlog_idx];
				end
				default: begin
					next_rdata = 32'h00000000;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			cfg_rdata  <= 32'h00000000;
			cfg_rd_ack <= 1'b0;
		end else begin
			cfg_rdata  <= next_rdata;
			cfg_rd_ack <= next_rd_ack;
		end
	end

endmodule // aum_uncor_regs

`default_nettype wire

// ### common/aum_params.svh
`ifndef AUM_PARAMS_SVH
`define AUM_PARAMS_SVH

// Register offsets within the error reporting capability
`define AUM_OFF_STATUS     12'h004
`define AUM_OFF_MASK       12'h008
`define AUM_OFF_SEVERITY   12'h00C
`define AUM_OFF_CAPCTL     12'h018
`define AUM_OFF_HLOG_FIRST 12'h01C
`define AUM_OFF_HLOG_LAST  12'h028

// Bit positions that carry a defined uncorrectable error
`define AUM_FIELD_BITS     32'h001FF030
// Optional errors are implemented unless a parameter removes them
`define AUM_IMPL_DEFAULT   32'h001FF030
// Reset values
`define AUM_MASK_DEFAULT   32'h00000000
`define AUM_SEV_DEFAULT    32'h00062030
`define AUM_STATUS_DEFAULT 32'h00000000
// Legacy position and the completion timeout position
`define AUM_BIT_LEGACY     32'h00000001
`define AUM_BIT_CPL_TMO    32'h00004000
// Field widths
`define AUM_PTR_W          5
`define AUM_HLOG_WORDS     4
`define AUM_HLOG_IDX_W     2

`endif

// ### common/aum_pkg.sv
`default_nettype none

package aum_pkg;

	typedef logic [31:0] aum_word_t;

	// Register select, one-hot
	typedef enum logic [5:0] {
		AUM_SEL_NONE   = 6'h01,
		AUM_SEL_STATUS = 6'h02,
		AUM_SEL_MASK   = 6'h04,
		AUM_SEL_SEV    = 6'h08,
		AUM_SEL_CAPCTL = 6'h10,
		AUM_SEL_HLOG   = 6'h20
	} aum_sel_e;

endpackage

`default_nettype wire

// ### logic/aum_ctl_bit.sv
`timescale 1ns/100ps
`default_nettype none

// One sticky read-write control bit; a bit that is not implemented stays at DFLT
module aum_ctl_bit #(
	parameter bit IMPL = 1'b1,
	parameter bit DFLT = 1'b0
) (
	input  wire logic clk,
	input  wire logic sys_rst,
	input  wire logic wr_en,
	input  wire logic wr_data,
	output var  logic q
);

	logic next_q;

	always_comb begin
		next_q = q;
		if (wr_en) begin
			next_q = wr_data;
		end
		if (!IMPL) begin
			next_q = DFLT;
		end
	end

	// Only the power-on reset reaches a sticky bit
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			q <= DFLT;
		end else begin
			q <= next_q;
		end
	end

endmodule // aum_ctl_bit

`default_nettype wire

// ### bench/aum_uncor_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module aum_uncor_monitor (
	input wire logic        clk,
	input wire logic        sys_rst,
	input wire logic        hot_rst,
	input wire logic        cfg_rd,
	input wire logic [11:0] cfg_addr,
	input wire logic [31:0] cfg_rdata,
	input wire logic        cfg_rd_ack,
	input wire logic [31:0] err_detect,
	input wire logic        err_fatal_msg,
	input wire logic        err_nonfatal_msg,
	input wire logic [4:0]  first_err_ptr
);
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	property p_ack; cfg_rd |=> cfg_rd_ack; endproperty
	a_ack: assert property (p_ack) else $error("read not acknowledged");
	property p_mrd; cfg_rd && cfg_addr == 12'h008 |=> (cfg_rdata & 32'hFFE00FCF) == 32'h0;
	endproperty
	a_mrd: assert property (p_mrd) else $error("mask unused bit set");
	property p_srd; cfg_rd && cfg_addr == 12'h00C |=> (cfg_rdata & 32'hFFE00FCF) == 32'h0;
	endproperty
	a_srd: assert property (p_srd) else $error("severity unused bit set");
	property p_fat; err_fatal_msg |-> $past(err_detect) != 32'h0; endproperty
	a_fat: assert property (p_fat) else $error("fatal message without error");
	property p_nf; err_nonfatal_msg |-> $past(err_detect) != 32'h0; endproperty
	a_nf: assert property (p_nf) else $error("nonfatal message without error");
	property p_hot; hot_rst |=> !err_fatal_msg && !err_nonfatal_msg; endproperty
	a_hot: assert property (p_hot) else $error("message during hot reset");
	// Pointer may only move on a detected error, never on a register access
	property p_ptr; $changed(first_err_ptr) |-> $past(err_detect) != 32'h0; endproperty
	a_ptr: assert property (p_ptr) else $error("pointer moved without error");
	property p_rst; $fell(sys_rst) |-> first_err_ptr == 5'h00 ##1 !err_fatal_msg; endproperty
	a_rst: assert property (p_rst) else $error("state not cleared by reset");
endmodule // aum_uncor_monitor
bind aum_uncor_regs aum_uncor_monitor aum_uncor_monitor_inst (.clk, .sys_rst, .hot_rst,
	.cfg_rd, .cfg_addr, .cfg_rdata, .cfg_rd_ack, .err_detect, .err_fatal_msg,
	.err_nonfatal_msg, .first_err_ptr);
`default_nettype wire

// ### bench/aum_root_model.sv
`timescale 1ns/100ps
`default_nettype none
// Counts error messages as the receiving side would see them
module aum_root_model (
	input  wire logic       clk,
	input  wire logic       sys_rst,
	input  wire logic       err_fatal_msg,
	input  wire logic       err_nonfatal_msg,
	output var  logic [7:0] n_fatal,
	output var  logic [7:0] n_nonfatal
);
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			n_fatal <= 8'h00;
			n_nonfatal <= 8'h00;
		end else begin
			n_fatal <= n_fatal + {7'h00, err_fatal_msg};
			n_nonfatal <= n_nonfatal + {7'h00, err_nonfatal_msg};
		end
	end
endmodule // aum_root_model
`default_nettype wire

// ### bench/aer_uncorrectable_mask_severity_bench.sv
`timescale 1ns/100ps
`default_nettype none
module aer_uncorrectable_mask_severity_bench import aum_pkg::*;;
	typedef struct {aum_word_t m; aum_word_t s; int b; logic [15:0] fn;} aum_row_s;
	logic         clk = 1'b0;
	logic         sys_rst = 1'b1;
	logic         hot_rst = 1'b0;
	logic         cfg_wr = 1'b0;
	logic         cfg_rd = 1'b0;
	logic [11:0]  cfg_addr = 12'h000;
	logic [3:0]   cfg_be = 4'hF;
	aum_word_t    cfg_wdata = 32'h0;
	aum_word_t    err_detect = 32'h0;
	logic [127:0] err_hdr = 128'hD3C2B1A0;
	wire  logic [31:0] cfg_rdata;
	wire  logic [31:0] np_rdata;
	wire  logic        ack, fat, nf;
	wire  logic [4:0]  ptr;
	wire  logic [7:0]  n_fatal, n_nonfatal;
	int failures = 0;
	int num_checks = 0;
	aum_word_t rv;
	aum_word_t rv2;
	// Expected counts are cumulative; software always writes 1 to mask bit 0
	aum_row_s rows [6] = '{
		'{32'h1, 32'h00062030, 4, 16'h0100},
		'{32'h1, 32'h00062030, 12, 16'h0101},
		'{32'h1, 32'h00062030, 18, 16'h0201},
		'{32'h00040001, 32'h00062030, 18, 16'h0201},
		'{32'h1, 32'h0, 18, 16'h0202},
		'{32'h1, 32'h00010000, 16, 16'h0302}};
	aum_uncor_regs aum_uncor_regs_inst (.clk, .sys_rst, .hot_rst, .cfg_wr, .cfg_rd, .cfg_addr,
		.cfg_be, .cfg_wdata, .cfg_rdata, .cfg_rd_ack(ack), .err_detect, .err_hdr,
		.err_fatal_msg(fat), .err_nonfatal_msg(nf), .first_err_ptr(ptr));
	aum_root_model aum_root_model_inst (.clk, .sys_rst, .err_fatal_msg(fat),
		.err_nonfatal_msg(nf), .n_fatal, .n_nonfatal);
	// Second copy: required errors only, switch port that issues no requests of its own
	aum_uncor_regs #(.IMPL_BITS(32'h00155010), .NO_OWN_NP(1'b1)) aum_uncor_regs_np_inst (.clk,
		.sys_rst, .hot_rst, .cfg_wr, .cfg_rd, .cfg_addr, .cfg_be, .cfg_wdata,
		.cfg_rdata(np_rdata), .cfg_rd_ack(), .err_detect, .err_hdr, .err_fatal_msg(),
		.err_nonfatal_msg(), .first_err_ptr());
	always #12.5 clk = ~clk;
	task automatic chk(aum_word_t got, aum_word_t exp);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(logic [11:0] a, aum_word_t d);
		@(negedge clk);
		cfg_wr = 1'b1;
		cfg_addr = a;
		cfg_wdata = d;
		@(negedge clk);
		cfg_wr = 1'b0;
	endtask
	task automatic rd(logic [11:0] a, output aum_word_t d);
		@(negedge clk);
		cfg_rd = 1'b1;
		cfg_addr = a;
		@(negedge clk);
		cfg_rd = 1'b0;
		chk({31'h0, ack}, 32'h1);
		d = cfg_rdata;
		rv2 = np_rdata;
	endtask
	// Extra cycle lets the message reach the counting model
	task automatic hit(int b);
		@(negedge clk);
		err_detect = 32'h1 << b;
		@(negedge clk);
		err_detect = 32'h0;
		@(negedge clk);
	endtask
	task automatic summarize();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial begin
		#100000;
		failures++;
		summarize();
	end
	initial begin
		repeat (6) @(negedge clk);
		sys_rst = 1'b0;
		rd(12'h008, rv); chk(rv, 32'h0);
		rd(12'h00C, rv); chk(rv, 32'h00062030);
		$display("test defaults done");
		foreach (rows[i]) begin
			wr(12'h008, rows[i].m);
			wr(12'h00C, rows[i].s);
			hit(rows[i].b);
			chk({16'h0, n_fatal, n_nonfatal}, {16'h0, rows[i].fn});
		end
		$display("test table done");
		chk({27'h0, ptr}, 32'h4);
		rd(12'h01C, rv); chk(rv, 32'hD3C2B1A0);
		rd(12'h004, rv); chk(rv, 32'h00051010);
		wr(12'h004, 32'h00001010);
		err_hdr = 128'h5 << 100;
		hit(20);
		chk({27'h0, ptr}, 32'h14);
		rd(12'h028, rv); chk(rv, 32'h50);
		rd(12'h004, rv); chk(rv, 32'h00150000);
		$display("test pointer done");
		wr(12'h008, 32'hFFFFFFFF);
		rd(12'h008, rv); chk(rv, 32'h001FF030);
		chk(rv2, 32'h00151010);
		wr(12'h00C, 32'hFFFFFFFF);
		rd(12'h00C, rv); chk(rv, 32'h001FF030);
		chk(rv2, 32'h00173030);
		wr(12'h00C, 32'h0);
		rd(12'h00C, rv);
		chk(rv, 32'h0);
		chk(rv2, 32'h00022020);
		rd(12'h0FC, rv); chk(rv, 32'h0);
		hot_rst = 1'b1;
		rd(12'h008, rv); chk(rv, 32'h001FF030);
		hot_rst = 1'b0;
		sys_rst = 1'b1;
		repeat (2) @(negedge clk);
		sys_rst = 1'b0;
		rd(12'h008, rv); chk(rv, 32'h0);
		hot_rst = 1'b1;
		hit(4);
		hot_rst = 1'b0;
		chk({16'h0, n_fatal, n_nonfatal}, 32'h0);
		$display("test sticky done");
		summarize();
	end
endmodule // aer_uncorrectable_mask_severity_bench
`default_nettype wire
